// ===== ofpc_map.svh
// Purpose: offsets, field positions, reset values and timing counts for the clock-control block
// Assumes: byte-wide registers, each in one aligned apb word
// Notes: definitions only
`ifndef OFPC_MAP_SVH
`define OFPC_MAP_SVH
`define OFPC_ADDR_W 20
`define OFPC_OSC_FREQ_DIVIDE_ADDR 20'hF00A8
`define OFPC_SUBSYS_CLOCK_SEL_ADDR 20'hF00F3
`define OFPC_PLL_CONTROL_ADDR 20'hF02E5
`define OFPC_SUBSYS_CLK_SEL_BIT 4
`define OFPC_REF_DIV_SEL_BIT 2
`define OFPC_MULT_SEL_BIT 1
`define OFPC_PLL_ENABLE_BIT 0
`define OFPC_BASE_FREQ_SEL_BIT 3
`define OFPC_SUBSYS_RESET 8'h00
`define OFPC_PLL_RESET 8'h00
`define OFPC_OSC_DIV_RESET 3'h0
`define OFPC_OLD_FREQ_CLKS 2'h3
`define OFPC_NEW_FREQ_CLKS 2'h3
`endif

// ===== ofpc_pkg.sv
// Purpose: types shared by the clock-control block
// Assumes: nothing beyond the map header
// Notes: state and status carriers
package ofpc_pkg;
	typedef enum logic [2:0] {
		OFPC_RUN = 3'h1,
		OFPC_OLD = 3'h2,
		OFPC_WAIT = 3'h4
	} ofpc_sw_t;
	typedef struct packed {
		logic [2:0] osc_div;
		logic valid;
		logic [5:0] mhz;
		logic switching;
		logic clk_stall;
	} ofpc_osc_t;
	typedef struct packed {
		logic run;
		logic ref_half;
		logic [4:0] vco_mult;
		logic [3:0] out_mult;
	} ofpc_pll_t;
	typedef struct packed {
		logic rtc_from_sel;
		logic itmr_from_lso;
		logic gtmr_lso_allowed;
		logic lso_run;
	} ofpc_route_t;
endpackage

// ===== ofpc_ctrl.sv
// Purpose: count-clock select, on-chip oscillator divide and pll control registers over apb
// Assumes: option byte bits and watchdog option are static straps from the option block
// Notes: the analog clock paths live outside; this block drives their controls
`include "ofpc_map.svh"
// Notes on behaviour
// RULE_01 - supply-mode register byte writes, resets zero
// RULE_02 - select zero: rtc clock drives rtc, interval
// RULE_03 - select one: interval timer from low-speed oscillator
// RULE_04 - software keeps select zero using rtc
// RULE_05 - divide field reset loads option byte bits
// RULE_06 - base select picks 24 or 32 MHz
// RULE_07 - codes divide by 1,2,4,8; others restricted; code also allows 4 and 5 (2 and 1 MHz) at the 32 MHz base
// RULE_08 - frequency select register byte writes only
// RULE_09 - three old clocks, then three stalled
// RULE_10 - software writes divide only on oscillator clock
// RULE_11 - software leaves pll before changing frequency
// RULE_12 - pll register bit or byte, resets zero
// RULE_13 - reference is system clock, optionally halved
// RULE_14 - multiplier select gives 12 or 16
// RULE_15 - output halved: effective six or eight
// RULE_16 - enable bit starts or stops pll
// RULE_17 - software changes divide, multiply only stopped
// RULE_18 - software keeps enable while pll selected
// RULE_19 - 4 MHz system clock needs undivided reference
// RULE_20 - software writes zero to pll bits 3-7
// RULE_21 - low-speed oscillator runs on select or watchdog
// RULE_22 - unused bits read zero, ignore writes
module ofpc_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`OFPC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [2:0] reset_freq_sel,
	input wire logic base_freq_sel,
	input wire logic watchdog_on_opt,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output ofpc_pkg::ofpc_osc_t osc_o,
	output ofpc_pkg::ofpc_pll_t pll_o,
	output ofpc_pkg::ofpc_route_t route_o
);
	import ofpc_pkg::*;

	typedef struct packed {
		logic [2:0] strap_s1;
		logic [2:0] strap_s2;
		logic base_s1;
		logic base_s2;
		logic wdt_s1;
		logic wdt_s2;
		logic strap_done;
		logic subsys_clk_sel;
		logic [2:0] osc_div;
		logic ref_div_sel;
		logic mult_sel;
		logic pll_enable;
		ofpc_sw_t sw;
		logic [1:0] cnt;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		ofpc_osc_t osc;
		ofpc_pll_t pll;
		ofpc_route_t route;
	} ofpc_state_t;

	ofpc_state_t s_q;
	ofpc_state_t s_d;

	// frequency in MHz for a divide code; zero marks a prohibited code
	// six bits: the 32 MHz top code does not fit in five
	function automatic logic [5:0] code_mhz(input logic [2:0] code, input logic base32);
		logic [5:0] base;
		base = base32 ? 6'h20 : 6'h18; // RULE_06
		case (code)
			3'h0: code_mhz = base; // RULE_07
			3'h1: code_mhz = base >> 1;
			3'h2: code_mhz = base >> 2;
			3'h3: code_mhz = base >> 3;
			3'h4: code_mhz = base32 ? 6'h02 : 6'h00;
			3'h5: code_mhz = base32 ? 6'h01 : 6'h00;
			default: code_mhz = 6'h00;
		endcase
	endfunction

	logic setup;
	logic access;
	logic wr;
	logic byte0;
	logic hit_sub;
	logic hit_div;
	logic hit_pll;
	logic byte_ok;

	assign setup = psel && !penable;
	assign access = psel && penable;
	assign hit_sub = paddr[`OFPC_ADDR_W-1:2] == `OFPC_SUBSYS_CLOCK_SEL_ADDR >> 2;
	assign hit_div = paddr[`OFPC_ADDR_W-1:2] == `OFPC_OSC_FREQ_DIVIDE_ADDR >> 2;
	assign hit_pll = paddr[`OFPC_ADDR_W-1:2] == `OFPC_PLL_CONTROL_ADDR >> 2;
	// byte data sits in the low lane; the byte lane must be written
	assign byte0 = pstrb[0];
	assign byte_ok = pwrite ? byte0 : 1'b1;
	assign wr = access && s_q.pready && pwrite && byte0;

	always_comb begin
		s_d = s_q;
		s_d.strap_s1 = reset_freq_sel;
		s_d.strap_s2 = s_q.strap_s1;
		s_d.base_s1 = base_freq_sel;
		s_d.base_s2 = s_q.base_s1;
		s_d.wdt_s1 = watchdog_on_opt;
		s_d.wdt_s2 = s_q.wdt_s1;
		// straps caught after reset release, not under the async reset
		if (!s_q.strap_done && s_q.cnt == 2'h2) begin
			s_d.osc_div = s_q.strap_s2; // RULE_05
			s_d.strap_done = 1'b1;
		end
		// no wait state: answer in the cycle after setup
		s_d.pready = setup;
		s_d.pslverr = setup && !((hit_sub || hit_div || hit_pll) && byte_ok);
		s_d.prdata = 32'h0;
		if (setup && !pwrite) begin
			if (hit_sub) s_d.prdata[`OFPC_SUBSYS_CLK_SEL_BIT] = s_q.subsys_clk_sel; // RULE_22
			if (hit_div) s_d.prdata[2:0] = s_q.osc_div;
			if (hit_pll) s_d.prdata[2:0] = {s_q.ref_div_sel, s_q.mult_sel, s_q.pll_enable};
		end
		if (wr && hit_sub) begin
			s_d.subsys_clk_sel = pwdata[`OFPC_SUBSYS_CLK_SEL_BIT]; // RULE_01
		end
		if (wr && hit_pll) begin
			s_d.ref_div_sel = pwdata[`OFPC_REF_DIV_SEL_BIT]; // RULE_12
			s_d.mult_sel = pwdata[`OFPC_MULT_SEL_BIT];
			s_d.pll_enable = pwdata[`OFPC_PLL_ENABLE_BIT];
		end
		// divide change: old clock runs, then clock stalls, then switch
		case (s_q.sw)
			OFPC_RUN: begin
				if (s_q.strap_done) begin
					s_d.cnt = 2'h0;
				end else begin
					s_d.cnt = s_q.cnt + 2'h1;
				end
				if (wr && hit_div && s_q.strap_done) begin
					s_d.osc_div = pwdata[2:0]; // RULE_08
					s_d.sw = OFPC_OLD;
					s_d.cnt = `OFPC_OLD_FREQ_CLKS;
				end
			end
			OFPC_OLD: begin
				s_d.cnt = s_q.cnt - 2'h1; // RULE_09
				if (s_q.cnt == 2'h1) begin
					s_d.sw = OFPC_WAIT;
					s_d.cnt = `OFPC_NEW_FREQ_CLKS;
				end
			end
			OFPC_WAIT: begin
				s_d.cnt = s_q.cnt - 2'h1; // RULE_09
				if (s_q.cnt == 2'h1) begin
					s_d.sw = OFPC_RUN;
					s_d.cnt = 2'h0;
				end
			end
			default: begin
				s_d.sw = OFPC_RUN;
				s_d.cnt = 2'h0;
			end
		endcase
		// the applied frequency only moves once the stall is over
		if (s_d.sw == OFPC_RUN) begin
			s_d.osc.osc_div = s_d.osc_div;
			s_d.osc.mhz = code_mhz(s_d.osc_div, s_q.base_s2); // RULE_07
			s_d.osc.valid = code_mhz(s_d.osc_div, s_q.base_s2) != 6'h00;
		end
		s_d.osc.switching = s_d.sw != OFPC_RUN;
		s_d.osc.clk_stall = s_d.sw == OFPC_WAIT; // RULE_09
		s_d.pll.run = s_d.pll_enable; // RULE_16
		s_d.pll.ref_half = s_d.ref_div_sel; // RULE_13
		s_d.pll.vco_mult = s_d.mult_sel ? 5'h10 : 5'h0C; // RULE_14
		s_d.pll.out_mult = s_d.mult_sel ? 4'h8 : 4'h6; // RULE_15
		s_d.route.rtc_from_sel = !s_d.subsys_clk_sel; // RULE_02
		s_d.route.itmr_from_lso = s_d.subsys_clk_sel; // RULE_03
		s_d.route.gtmr_lso_allowed = s_d.subsys_clk_sel; // RULE_03
		s_d.route.lso_run = s_d.subsys_clk_sel || s_q.wdt_s2; // RULE_21
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.subsys_clk_sel <= 1'(`OFPC_SUBSYS_RESET >> `OFPC_SUBSYS_CLK_SEL_BIT); // RULE_01
			s_q.pll_enable <= 1'b0; // RULE_12
			s_q.osc_div <= `OFPC_OSC_DIV_RESET;
			s_q.sw <= OFPC_RUN;
			s_q.pll.vco_mult <= 5'h0C;
			s_q.pll.out_mult <= 4'h6;
			s_q.route.rtc_from_sel <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign osc_o = s_q.osc;
	assign pll_o = s_q.pll;
	assign route_o = s_q.route;
endmodule // ofpc_ctrl

// ===== ofpc_ctrl_asserts.sv
// Purpose: port checks for the clock-control block
// Assumes: straps change only under reset
// Notes: bound from the test top
module ofpc_ctrl_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic base_freq_sel,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire ofpc_pkg::ofpc_osc_t osc_o,
	input wire ofpc_pkg::ofpc_pll_t pll_o,
	input wire ofpc_pkg::ofpc_route_t route_o
);
	import ofpc_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_route; route_o.rtc_from_sel != route_o.itmr_from_lso; endproperty
	a_route: assert property (p_route) else $error("route");
	property p_lso; route_o.itmr_from_lso |-> route_o.lso_run; endproperty
	a_lso: assert property (p_lso) else $error("lso");
	property p_vco; pll_o.vco_mult inside {5'h0C, 5'h10}; endproperty
	a_vco: assert property (p_vco) else $error("vco");
	property p_half; pll_o.vco_mult == {pll_o.out_mult, 1'b0}; endproperty
	a_half: assert property (p_half) else $error("half");
	property p_rd; pready |-> prdata[31:5] == 27'h0; endproperty
	a_rd: assert property (p_rd) else $error("rdata");
	property p_stall; $rose(osc_o.switching) |-> (!osc_o.clk_stall)[*3]
		##1 osc_o.clk_stall[*3] ##1 !osc_o.switching; endproperty
	a_stall: assert property (p_stall) else $error("stall");
	property p_mhz; osc_o.valid && osc_o.osc_div != 3'h0 |->
		osc_o.mhz == ((base_freq_sel ? 6'h20 : 6'h18) >> osc_o.osc_div); endproperty
	a_mhz: assert property (p_mhz) else $error("mhz");
	property p_bad; osc_o.osc_div > 3'h5 || (osc_o.osc_div[2] && !base_freq_sel) |->
		!osc_o.valid && osc_o.mhz == 6'h00; endproperty
	a_bad: assert property (p_bad) else $error("bad");
endmodule // ofpc_ctrl_asserts

// ===== ofpc_ctrl_test.sv
// Purpose: register-level test of the clock-control block
// Assumes: one-cycle apb answer
// Notes: base select changes only while reset is held
`include "ofpc_map.svh"
module ofpc_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	import ofpc_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, base = 0, wdo = 0;
	logic [19:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, r;
	logic [3:0] pstrb = '0;
	logic pready, pslverr, e;
	ofpc_osc_t osc_o;
	ofpc_pll_t pll_o;
	ofpc_route_t route_o;
	int n_fail = 0, checked = 0;
	ofpc_ctrl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.reset_freq_sel(3'h2), .base_freq_sel(base), .watchdog_on_opt(wdo), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_o(osc_o), .pll_o(pll_o), .route_o(route_o));
	always #12.5 pclk = ~pclk;
	task automatic print_verdict();
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic xfer(input logic w, input logic [19:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i == 16) begin
			n_fail++;
			print_verdict();
		end
	endtask
	initial begin
		int c;
		for (int b = 0; b < 2; b++) begin
			presetn <= 1'b0;
			base <= b[0];
			repeat (5) @(posedge pclk);
			presetn <= 1'b1;
			repeat (6) @(posedge pclk);
			xfer(0, `OFPC_OSC_FREQ_DIVIDE_ADDR, 8'h0, 4'h1);
			chk("div", 32'h2, r);
			chk("mhz", b ? 32'h8 : 32'h6, {26'h0, osc_o.mhz});
			for (c = 0; c < 7; c++) begin
				xfer(1, `OFPC_OSC_FREQ_DIVIDE_ADDR, c[7:0], 4'h1);
				@(posedge pclk);
				for (int i = 0; i < 20 && osc_o.switching !== 1'b0; i++) @(posedge pclk);
				chk("valid", c < 6 && (b || c < 4), {31'h0, osc_o.valid});
				chk("mhz", (c < 6 && (b || c < 4)) ? (b ? 32 : 24) >> c : 0,
					{26'h0, osc_o.mhz});
			end
			xfer(1, `OFPC_OSC_FREQ_DIVIDE_ADDR, 8'h3, 4'h0);
			chk("lane", 32'h1, {31'h0, e});
			xfer(0, `OFPC_OSC_FREQ_DIVIDE_ADDR, 8'h0, 4'h1);
			chk("div", 32'h6, r);
			xfer(0, `OFPC_SUBSYS_CLOCK_SEL_ADDR, 8'h0, 4'h1);
			chk("sub", 32'h0, r);
			xfer(1, `OFPC_SUBSYS_CLOCK_SEL_ADDR, 8'hFF, 4'h1);
			xfer(0, `OFPC_SUBSYS_CLOCK_SEL_ADDR, 8'h0, 4'h1);
			chk("sub", 32'h10, r);
			chk("route", 32'h3, {29'h0, route_o[3:1]});
			xfer(1, `OFPC_SUBSYS_CLOCK_SEL_ADDR, 8'h0, 4'h1);
			xfer(0, `OFPC_PLL_CONTROL_ADDR, 8'h0, 4'h1);
			chk("pll", 32'h0, r);
			chk("route", 32'h4, {29'h0, route_o[3:1]});
			xfer(1, `OFPC_PLL_CONTROL_ADDR, 8'h07, 4'h1);
			xfer(0, `OFPC_PLL_CONTROL_ADDR, 8'h0, 4'h1);
			chk("pll", 32'h7, r);
			chk("pllo", {21'h0, 2'h3, 5'h10, 4'h8}, {21'h0, pll_o});
			xfer(1, `OFPC_PLL_CONTROL_ADDR, 8'h0, 4'h1);
			xfer(0, 20'h00000, 8'h0, 4'h1);
			chk("unmapped", 32'h1, {31'h0, e});
			chk("pllo", {21'h0, 2'h0, 5'h0C, 4'h6}, {21'h0, pll_o});
		end
		wdo <= 1'b1;
		for (int i = 0; i < 8 && route_o.lso_run !== 1'b1; i++) @(posedge pclk);
		chk("lso", 32'h1, {31'h0, route_o.lso_run});
		print_verdict();
	end
endmodule // ofpc_ctrl_test
bind ofpc_ctrl ofpc_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn),
	.base_freq_sel(base_freq_sel), .prdata(prdata), .pready(pready), .osc_o(osc_o),
	.pll_o(pll_o), .route_o(route_o));
